// *** rtl/eiw_top.sv ***
// External edge interrupt, wake from sleep, vectoring and automatic context save.
// ***************************************************************
// Operation
// - Only clockless-capable enabled sources end sleep.
// - Wake with global enable set vectors.
// - Wake with global enable clear continues sequentially.
// - One instruction after sleep runs before vectoring.
// - Pin edges form an enabled edge interrupt.
// - Edge select one is rising, zero falling.
// - Selected edge sets the external request flag.
// - Flag with both enables redirects to vector.
// - Entry pushes the return address on stack.
// - Entry copies context registers into shadows.
// - Return reloads context from shadow copies.
// - Software-written shadow value is what returns.
// - Shadows sit in data bank 31, read/write.
// ***************************************************************
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module eiw_top #(
  parameter int                PER_N        = 4,
  parameter logic [PER_N-1:0]  WAKE_CAPABLE = 4'h1,
  parameter int                PC_W         = 15
) (
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic [11:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   ext_edge_irq_pin,
  input  wire logic [PER_N-1:0]       periph_irq_req,
  input  wire logic                   core_sleep_exec,
  input  wire logic                   core_instr_done,
  input  wire logic                   core_irq_return,
  input  wire logic [PC_W-1:0]        core_ret_pc,
  input  wire eiw_pkg::eiw_ctx_type   core_ctx_live,
  output logic                        core_run,
  output logic                        core_sleeping,
  output logic                        irq_vector_req,
  output logic                        stack_push,
  output logic [PC_W-1:0]             stack_push_pc,
  output logic                        ctx_restore,
  output eiw_pkg::eiw_ctx_type        ctx_restore_data,
  output eiw_pkg::eiw_ctx_type        ctx_restore_mask
);
  import eiw_pkg::*;

  if (PER_N < 1 || PER_N > 4) begin : g_bad_per_n
    $error("PER_N must lie between 1 and 4");
  end

  // ***************************************************************
  // Declarations
  // ***************************************************************
  eiw_ctx_if ctx ();

  eiw_state_type    st_q;
  eiw_state_type    st_d;
  logic             glb_en_q;
  logic             edge_sel_q;
  logic             ext_en_q;
  logic [PER_N-1:0] per_en_q;
  logic             ext_flag_q;
  logic             pin_q;
  logic             edge_hit;
  logic             ext_active;
  logic             wake_any;
  logic             irq_pending;
  logic [PC_W-1:0]  ret_pc_q;
  logic             restore_q;
  logic             ack_q;
  logic             err_q;
  logic [31:0]      rdata_q;
  logic [31:0]      rd_d;
  logic             hit_d;
  logic             shadow_hit;
  logic             setup;
  logic             fire_wr;
  logic             lane0_wr;

  // ***************************************************************
  // APB slave
  // ***************************************************************
  assign setup      = psel && !penable;
  assign pready     = penable && ack_q;
  assign pslverr    = penable && ack_q && err_q;
  assign prdata     = rdata_q;
  assign fire_wr    = psel && penable && pready && pwrite && !err_q;
  assign lane0_wr   = fire_wr && pstrb[0];
  assign shadow_hit = paddr[11:5] == OFS_SHADOW_BASE[11:5];

  always_comb begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    if (shadow_hit) begin
      rd_d[7:0] = ctx.shadow[paddr[4:2]];
    end else begin
      case (paddr)
        OFS_CONTROL: begin
          rd_d[CTL_GLB_EN_BIT] = glb_en_q;
          rd_d[CTL_EDGE_BIT]   = edge_sel_q;
        end
        OFS_ENABLE0: begin
          rd_d[PER_N-1:0] = per_en_q;
          rd_d[EXT_BIT]   = ext_en_q;
        end
        OFS_REQUEST0: begin
          rd_d[PER_N-1:0] = periph_irq_req;
          rd_d[EXT_BIT]   = ext_flag_q;
        end
        OFS_CORE_STATE: begin
          rd_d[STATE_SLP_BIT] = st_q == ST_SLEEP;
          rd_d[STATE_HND_BIT] = st_q == ST_IN_HANDLER || st_q == ST_ENTRY;
        end
        default: begin
          hit_d = 1'b0;
        end
      endcase
    end
    if (paddr[1:0] != 2'b00) begin
      hit_d = 1'b0;
    end
  end

  // Read data and the error answer are prepared in the setup cycle.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= setup;
      if (setup) begin
        err_q   <= !hit_d;
        rdata_q <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  // ***************************************************************
  // Control and enable registers
  // ***************************************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_sel_q <= EDGE_SEL_RST;
      ext_en_q   <= EXT_EN_RST;
      per_en_q   <= '0;
    end else if (lane0_wr && paddr == OFS_CONTROL) begin
      edge_sel_q <= pwdata[CTL_EDGE_BIT];
    end else if (lane0_wr && paddr == OFS_ENABLE0) begin
      ext_en_q <= pwdata[EXT_BIT];
      per_en_q <= pwdata[PER_N-1:0];
    end
  end

  // The hardware clears the global enable on entry and sets it on return; it wins over software.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      glb_en_q <= GLB_EN_RST;
    end else if (st_q == ST_ENTRY) begin
      glb_en_q <= 1'b0;
    end else if (st_q == ST_IN_HANDLER && core_irq_return) begin
      glb_en_q <= 1'b1;
    end else if (lane0_wr && paddr == OFS_CONTROL) begin
      glb_en_q <= pwdata[CTL_GLB_EN_BIT];
    end
  end

  // ***************************************************************
  // External edge detector and request flag
  // ***************************************************************
  assign edge_hit = edge_sel_q ? (ext_edge_irq_pin && !pin_q)
                               : (!ext_edge_irq_pin && pin_q);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= ext_edge_irq_pin;
    end
  end

  // Writing zero to the flag bit clears it; an edge in the same cycle wins.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_flag_q <= 1'b0;
    end else if (edge_hit) begin
      ext_flag_q <= 1'b1;
    end else if (lane0_wr && paddr == OFS_REQUEST0 && !pwdata[EXT_BIT]) begin
      ext_flag_q <= 1'b0;
    end
  end

  // ***************************************************************
  // Wake and vector decision
  // ***************************************************************
  assign ext_active  = ext_flag_q && ext_en_q;
  assign wake_any    = ext_active || |(periph_irq_req & per_en_q & WAKE_CAPABLE);
  assign irq_pending = glb_en_q && (ext_active || |(periph_irq_req & per_en_q));

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (core_sleep_exec) begin
          st_d = ST_SLEEP;
        end else if (core_instr_done && irq_pending) begin
          st_d = ST_ENTRY;
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          st_d = glb_en_q ? ST_WAKE_STEP : ST_RUN;
        end
      end
      ST_WAKE_STEP: begin
        if (core_instr_done) begin
          st_d = ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        st_d = ST_IN_HANDLER;
      end
      ST_IN_HANDLER: begin
        if (core_irq_return) begin
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // The return address is the one after the instruction that completed on the way in.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ret_pc_q <= '0;
    end else if (st_d == ST_ENTRY && st_q != ST_ENTRY) begin
      ret_pc_q <= core_ret_pc;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      restore_q <= 1'b0;
    end else begin
      restore_q <= st_q == ST_IN_HANDLER && core_irq_return;
    end
  end

  // ***************************************************************
  // Core side outputs and shadow bank
  // ***************************************************************
  assign core_run         = st_q != ST_SLEEP;
  assign core_sleeping    = st_q == ST_SLEEP;
  assign irq_vector_req   = st_q == ST_ENTRY;
  assign stack_push       = st_q == ST_ENTRY;
  assign stack_push_pc    = ret_pc_q;
  assign ctx_restore      = restore_q;
  assign ctx_restore_data = ctx.shadow;
  assign ctx_restore_mask = SHD_SAVE_MASK;

  assign ctx.save    = st_q == ST_ENTRY;
  assign ctx.live    = core_ctx_live;
  assign ctx.sw_we   = lane0_wr && shadow_hit;
  assign ctx.sw_idx  = paddr[4:2];
  assign ctx.sw_data = pwdata[7:0];

  eiw_shadow_bank u_shadow (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ctx      (ctx.store)
  );

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wake_vec_armed;
    st_q == ST_SLEEP && wake_any && glb_en_q;
  endsequence
  sequence s_wake_step_done;
    st_q == ST_WAKE_STEP && core_instr_done;
  endsequence

  property p_edge_sets;
    edge_hit |=> ext_flag_q;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

  property p_wrong_edge;
    ext_edge_irq_pin && !pin_q && !edge_sel_q && !ext_flag_q |=> !ext_flag_q;
  endproperty
  a_wrong_edge: assert property (p_wrong_edge) else $error("rising edge set flag");

  property p_flag_holds;
    ext_flag_q && !(lane0_wr && paddr == OFS_REQUEST0) |=> ext_flag_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

  property p_sleep_stays;
    st_q == ST_SLEEP && !wake_any |=> st_q == ST_SLEEP && !core_run;
  endproperty
  a_sleep_stays: assert property (p_sleep_stays) else $error("woke without source");

  property p_wake_step;
    s_wake_vec_armed |=> st_q == ST_WAKE_STEP && core_run && !irq_vector_req;
  endproperty
  a_wake_step: assert property (p_wake_step) else $error("no single step after wake");

  property p_wake_vec;
    s_wake_step_done |=> irq_vector_req && stack_push;
  endproperty
  a_wake_vec: assert property (p_wake_vec) else $error("no vector after wake");

  property p_wake_seq;
    st_q == ST_SLEEP && wake_any && !glb_en_q |=> st_q == ST_RUN ##1 !irq_vector_req;
  endproperty
  a_wake_seq: assert property (p_wake_seq) else $error("vectored with global enable clear");

  property p_one_step;
    st_q == ST_WAKE_STEP && !core_instr_done |=> !irq_vector_req && core_run;
  endproperty
  a_one_step: assert property (p_one_step) else $error("vectored before step");

  property p_take;
    st_q == ST_RUN && !core_sleep_exec && core_instr_done && irq_pending
      |=> irq_vector_req && stack_push_pc == $past(core_ret_pc) ##1 !glb_en_q;
  endproperty
  a_take: assert property (p_take) else $error("interrupt not taken");

  property p_save;
    ctx.save |=> ctx.shadow[SHD_STATUS] == ($past(core_ctx_live[SHD_STATUS]) & STATUS_SAVE_MASK)
                 && ctx.shadow[SHD_WREG] == $past(core_ctx_live[SHD_WREG]);
  endproperty
  a_save: assert property (p_save) else $error("context not saved");

  property p_sw_shadow;
    ctx.sw_we && !ctx.save && ctx.sw_idx == 3'(SHD_BANK)
      |=> ctx_restore_data[SHD_BANK] == $past(pwdata[7:0]);
  endproperty
  a_sw_shadow: assert property (p_sw_shadow) else $error("shadow write lost");

  property p_restore;
    st_q == ST_IN_HANDLER && core_irq_return |=> ctx_restore && st_q == ST_RUN && glb_en_q;
  endproperty
  a_restore: assert property (p_restore) else $error("no restore on return");

endmodule
`default_nettype wire

// *** rtl/eiw_pkg.sv ***
// Package of constants and types for the external interrupt, wake and context save block.
package eiw_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFS_CONTROL     = 12'h000;
  localparam logic [11:0] OFS_ENABLE0     = 12'h004;
  localparam logic [11:0] OFS_REQUEST0    = 12'h008;
  localparam logic [11:0] OFS_CORE_STATE  = 12'h00C;
  localparam int          DATA_BANK_SIZE  = 128;
  localparam int          SHADOW_BANK     = 31;
  localparam logic [11:0] OFS_SHADOW_BASE = 12'(SHADOW_BANK * DATA_BANK_SIZE);

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int         CTL_GLB_EN_BIT = 7;
  localparam int         CTL_EDGE_BIT   = 0;
  localparam int         EXT_BIT        = 4;
  localparam int         STATE_SLP_BIT  = 0;
  localparam int         STATE_HND_BIT  = 1;
  localparam logic       GLB_EN_RST     = 1'b0;
  localparam logic       EDGE_SEL_RST   = 1'b1;
  localparam logic       EXT_EN_RST     = 1'b0;
  localparam logic [7:0] SHADOW_RST     = 8'h00;

  // ***************************************************************
  // Shadow copies
  // ***************************************************************
  localparam int SHD_N      = 8;
  localparam int SHD_IDX_W  = 3;
  localparam int SHD_WREG   = 0;
  localparam int SHD_STATUS = 1;
  localparam int SHD_BANK   = 2;
  localparam int SHD_PTR0_L = 3;
  localparam int SHD_PTR0_H = 4;
  localparam int SHD_PTR1_L = 5;
  localparam int SHD_PTR1_H = 6;
  localparam int SHD_PC_HI  = 7;

  localparam logic [7:0] STATUS_TIMEOUT_MASK   = 8'h10;
  localparam logic [7:0] STATUS_POWERDOWN_MASK = 8'h08;
  localparam logic [7:0] STATUS_SAVE_MASK      = ~(STATUS_TIMEOUT_MASK | STATUS_POWERDOWN_MASK);
  localparam logic [SHD_N-1:0][7:0] SHD_SAVE_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF,
                                                     8'hFF, 8'hFF, STATUS_SAVE_MASK, 8'hFF};

  typedef logic [SHD_N-1:0][7:0] eiw_ctx_type;

  // ***************************************************************
  // Sequencer states
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_STEP,
    ST_ENTRY,
    ST_IN_HANDLER
  } eiw_state_type;

endpackage

// *** rtl/eiw_ctx_if.sv ***
// Interface carrying context save and software access between sequencer and shadow bank.
`timescale 1ns/10ps
`default_nettype none
interface eiw_ctx_if;
  import eiw_pkg::*;
  logic                 save;
  logic                 sw_we;
  logic [SHD_IDX_W-1:0] sw_idx;
  logic [7:0]           sw_data;
  eiw_ctx_type          live;
  eiw_ctx_type          shadow;

  modport ctl (output save, output sw_we, output sw_idx, output sw_data, output live,
               input shadow);
  modport store (input save, input sw_we, input sw_idx, input sw_data, input live,
                 output shadow);
endinterface
`default_nettype wire

// *** rtl/eiw_shadow_bank.sv ***
// Shadow copies of the core context, saved on interrupt entry and writable by software.
`timescale 1ns/10ps
`default_nettype none
module eiw_shadow_bank (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  eiw_ctx_if.store  ctx
);
  import eiw_pkg::*;

  logic [7:0] shd_q [SHD_N];

  for (genvar i = 0; i < SHD_N; i++) begin : g_ent
    // Entry save takes priority; the core is not executing software in that cycle.
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        shd_q[i] <= SHADOW_RST;
      end else if (ctx.save) begin
        shd_q[i] <= ctx.live[i] & SHD_SAVE_MASK[i];
      end else if (ctx.sw_we && ctx.sw_idx == SHD_IDX_W'(i)) begin
        shd_q[i] <= ctx.sw_data & SHD_SAVE_MASK[i];
      end
    end
    assign ctx.shadow[i] = shd_q[i];
  end

endmodule
`default_nettype wire

// *** tb/eiw_core_model.sv ***
// Behavioural model of the processor core sequencer and register file.
`timescale 1ns/10ps
`default_nettype none
module eiw_core_model #(
  parameter int PC_W = 15
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 stall,
  input  wire logic                 ctx_load,
  input  wire eiw_pkg::eiw_ctx_type ctx_in,
  input  wire logic                 core_run,
  input  wire logic                 ctx_restore,
  input  wire eiw_pkg::eiw_ctx_type ctx_restore_data,
  input  wire eiw_pkg::eiw_ctx_type ctx_restore_mask,
  output logic                      core_instr_done,
  output logic [PC_W-1:0]           core_ret_pc,
  output eiw_pkg::eiw_ctx_type      core_ctx_live
);
  import eiw_pkg::*;
  // ***************************************************************
  // Instruction stream
  // ***************************************************************
  // An instruction retires in every running cycle unless the bench stalls the core.
  assign core_instr_done = core_run & ~stall;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_ret_pc <= '0;
    end else if (core_instr_done) begin
      core_ret_pc <= core_ret_pc + 1'b1;
    end
  end
  // ***************************************************************
  // Register file
  // ***************************************************************
  // Masked bits keep their live value when the context comes back.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_ctx_live <= '0;
    end else if (ctx_restore) begin
      core_ctx_live <= (ctx_restore_data & ctx_restore_mask)
                       | (core_ctx_live & ~ctx_restore_mask);
    end else if (ctx_load) begin
      core_ctx_live <= ctx_in;
    end
  end
endmodule
`default_nettype wire

// *** tb/ext_irq_wake_context_save_tb.sv ***
// Self-checking testbench of the interrupt, wake and context save block.
`timescale 1ns/10ps
`default_nettype none
module ext_irq_wake_context_save_tb;
  import eiw_pkg::*;
  logic        core_clk, sys_rst, psel, penable, pwrite, pin, sleep_x, ret_x, stall, ld;
  logic        pready, pslverr, run, slp, vec, push, rst_p, done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, preq;
  logic [14:0] ret_pc, push_pc, pc_prev;
  eiw_ctx_type live, ctx_in, rdat, rmask, c0, exp_ctx;
  int          err_count = 0;
  int          total_checks = 0;
  int          vec_cnt = 0;

  eiw_top uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_edge_irq_pin(pin),
    .periph_irq_req(preq), .core_sleep_exec(sleep_x), .core_instr_done(done),
    .core_irq_return(ret_x), .core_ret_pc(ret_pc), .core_ctx_live(live),
    .core_run(run), .core_sleeping(slp), .irq_vector_req(vec), .stack_push(push),
    .stack_push_pc(push_pc), .ctx_restore(rst_p), .ctx_restore_data(rdat),
    .ctx_restore_mask(rmask)
  );
  eiw_core_model cm (
    .core_clk(core_clk), .sys_rst(sys_rst), .stall(stall), .ctx_load(ld),
    .ctx_in(ctx_in), .core_run(run), .ctx_restore(rst_p), .ctx_restore_data(rdat),
    .ctx_restore_mask(rmask), .core_instr_done(done), .core_ret_pc(ret_pc),
    .core_ctx_live(live)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    pc_prev <= ret_pc;
    if (vec === 1'b1) begin
      vec_cnt <= vec_cnt + 1;
    end
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic ee);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      chk(1'b0, "bus hang");
      give_verdict();
    end
    chk(pslverr === ee && (w || prdata === {24'h000000, e}), $sformatf("bus at %h", a));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, e, 1'b0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 8'h00, 1'b0);
  endtask
  task automatic wait_on(input int s);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if ((s == 0 && vec === 1'b1) || (s == 1 && rst_p === 1'b1) ||
          (s == 2 && run === 1'b1)) break;
    end
    if (n == 200) begin
      chk(1'b0, "wait timeout");
      give_verdict();
    end
  endtask
  task automatic pulse(input int s);
    @(posedge core_clk);
    if (s == 0) begin
      sleep_x <= 1'b1;
    end else begin
      ret_x <= 1'b1;
    end
    @(posedge core_clk);
    sleep_x <= 1'b0;
    ret_x <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic load(input eiw_ctx_type v);
    ctx_in <= v;
    ld <= 1'b1;
    @(posedge core_clk);
    ld <= 1'b0;
  endtask
  function automatic logic [11:0] sh(input int i);
    return 12'(OFS_SHADOW_BASE + 4 * i);
  endfunction

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    int i;
    int s;
    int n;
    sys_rst = 1'b1;
    {psel, penable, pwrite, pin, sleep_x, ret_x, stall, ld} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    preq = 4'h0;
    ctx_in = '0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_CONTROL, 8'h01);
    rd(OFS_ENABLE0, 8'h00);
    rd(OFS_REQUEST0, 8'h00);
    rd(OFS_CORE_STATE, 8'h00);
    apb(1'b0, 12'h010, 8'h00, 8'h00, 1'b1);
    apb(1'b1, 12'h001, 8'h80, 8'h00, 1'b1);
    rd(OFS_CONTROL, 8'h01);
    pstrb <= 4'hE;
    wr(OFS_CONTROL, 8'h80);
    pstrb <= 4'hF;
    rd(OFS_CONTROL, 8'h01);
    for (i = 0; i < SHD_N; i++) begin
      rd(sh(i), 8'h00);
      wr(sh(i), 8'hFF);
      rd(sh(i), (i == SHD_STATUS) ? 8'hE7 : 8'hFF);
    end
    $display("Test registers done, errors %0d", err_count);
    for (s = 1; s >= 0; s--) begin
      wr(OFS_CONTROL, {7'h00, s[0]});
      pin <= ~s[0];
      idle(3);
      wr(OFS_REQUEST0, 8'h00);
      pin <= s[0];
      idle(3);
      rd(OFS_REQUEST0, 8'h10);
      idle(10);
      wr(OFS_REQUEST0, 8'hFF);
      rd(OFS_REQUEST0, 8'h10);
      wr(OFS_REQUEST0, 8'h00);
      pin <= ~s[0];
      idle(3);
      rd(OFS_REQUEST0, 8'h00);
    end
    preq <= 4'hA;
    rd(OFS_REQUEST0, 8'h0A);
    preq <= 4'h0;
    $display("Test edges done, errors %0d", err_count);
    c0 = {8'h77, 8'h66, 8'h55, 8'h44, 8'h33, 8'h22, 8'h24, 8'h11};
    load(c0);
    wr(OFS_CONTROL, 8'h01);
    pin <= 1'b0;
    wr(OFS_ENABLE0, 8'h10);
    wr(OFS_CONTROL, 8'h81);
    pin <= 1'b1;
    wait_on(0);
    chk(push === 1'b1 && push_pc === pc_prev, "return address");
    rd(OFS_CORE_STATE, 8'h02);
    rd(OFS_CONTROL, 8'h01);
    for (i = 0; i < SHD_N; i++) begin
      rd(sh(i), c0[i] & ((i == SHD_STATUS) ? 8'hE7 : 8'hFF));
    end
    load({8{8'hFF}});
    wr(sh(SHD_WREG), 8'h5A);
    wr(OFS_REQUEST0, 8'h00);
    pulse(1);
    wait_on(1);
    idle(1);
    exp_ctx = c0;
    exp_ctx[SHD_WREG] = 8'h5A;
    exp_ctx[SHD_STATUS] = 8'h3C;
    chk(live === exp_ctx, "restored context");
    rd(OFS_CONTROL, 8'h81);
    rd(OFS_CORE_STATE, 8'h00);
    $display("Test context done, errors %0d", err_count);
    wr(OFS_CONTROL, 8'h01);
    wr(OFS_ENABLE0, 8'h00);
    pin <= 1'b0;
    pulse(0);
    idle(2);
    chk(slp === 1'b1 && run === 1'b0, "sleep entry");
    rd(OFS_CORE_STATE, 8'h01);
    pin <= 1'b1;
    idle(5);
    chk(slp === 1'b1, "woke on disabled source");
    wr(OFS_REQUEST0, 8'h00);
    wr(OFS_ENABLE0, 8'h02);
    preq <= 4'h2;
    idle(5);
    chk(slp === 1'b1, "woke on clocked source");
    preq <= 4'h0;
    wr(OFS_ENABLE0, 8'h01);
    preq <= 4'h1;
    n = vec_cnt;
    wait_on(2);
    idle(10);
    preq <= 4'h0;
    chk(vec_cnt == n && slp === 1'b0, "vector with global enable clear");
    pin <= 1'b0;
    wr(OFS_ENABLE0, 8'h10);
    wr(OFS_CONTROL, 8'h81);
    stall <= 1'b1;
    pulse(0);
    idle(2);
    pin <= 1'b1;
    n = vec_cnt;
    wait_on(2);
    idle(5);
    chk(vec_cnt == n && run === 1'b1, "vector before next instruction");
    stall <= 1'b0;
    wait_on(0);
    wr(OFS_REQUEST0, 8'h00);
    pulse(1);
    wait_on(1);
    $display("Test sleep done, errors %0d", err_count);
    give_verdict();
  end
endmodule
`default_nettype wire
